// ### design/udwsc_counter.sv
`timescale 1ns/1ps
`include "udwsc_consts.svh"
module udwsc_counter
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset_n,
	// Host pins.
	input wire udwsc_pkg::udwsc_host_t host, // R9
	// Wiper code.
	output udwsc_pkg::udwsc_wiper_t wiper,
	output logic step_pulse
);
	////////////////////////////////////////////////////////////////////////
	// Pins come from outside this clock, so each passes three flip-flops.
	logic [2:0] clk_sync_reg, clk_sync_next;
	logic [2:0] sel_sync_reg, sel_sync_next;
	logic [2:0] dir_sync_reg, dir_sync_next;
	logic clk_level_reg, clk_level_next;
	logic sel_level_reg, sel_level_next;
	logic dir_level_reg, dir_level_next;

	always_comb
	begin
		clk_sync_next = {clk_sync_reg[1:0], host.step_clk};
		sel_sync_next = {sel_sync_reg[1:0], host.select_n};
		dir_sync_next = {dir_sync_reg[1:0], host.dir_up};
		clk_level_next = clk_level_reg;
		sel_level_next = sel_level_reg;
		dir_level_next = dir_level_reg;
		if (clk_sync_reg[1] == clk_sync_reg[2])
		begin
			clk_level_next = clk_sync_reg[2];
		end
		if (sel_sync_reg[1] == sel_sync_reg[2])
		begin
			sel_level_next = sel_sync_reg[2];
		end
		if (dir_sync_reg[1] == dir_sync_reg[2])
		begin
			dir_level_next = dir_sync_reg[2];
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			clk_sync_reg <= `UDWSC_SYNC_HIGH;
			sel_sync_reg <= `UDWSC_SYNC_HIGH;
			dir_sync_reg <= `UDWSC_SYNC_LOW;
			clk_level_reg <= 1'b1;
			sel_level_reg <= 1'b1;
			dir_level_reg <= 1'b0;
		end
		else
		begin
			clk_sync_reg <= clk_sync_next;
			sel_sync_reg <= sel_sync_next;
			dir_sync_reg <= dir_sync_next;
			clk_level_reg <= clk_level_next;
			sel_level_reg <= sel_level_next;
			dir_level_reg <= dir_level_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// A qualifying edge is a filtered fall of the step clock while selected.
	// Select and direction use the same filter depth, so the host setup time
	// carries over to the filtered levels.
	logic fall;
	logic [`UDWSC_POS_W-1:0] pos_reg, pos_next;
	logic step_reg, step_next;
	// The high-end code is registered so that every output leaves a flip-flop.
	logic [`UDWSC_POS_W-1:0] high_reg, high_next;

	always_comb
	begin
		fall = clk_level_reg && (clk_sync_reg[1] == clk_sync_reg[2]) && !clk_sync_reg[2]; // R3
		pos_next = pos_reg;
		step_next = 1'b0;
		if (fall && !sel_level_reg) // R3 R10 R12
		begin
			step_next = 1'b1;
			if (dir_level_reg) // R5 R7 R11
			begin
				if (pos_reg != `UDWSC_POS_MAX) // R6
					pos_next = pos_reg + `UDWSC_POS_ONE; // R4
			end
			else if (pos_reg != `UDWSC_POS_MIN) // R6
				pos_next = pos_reg - `UDWSC_POS_ONE; // R4
		end
		high_next = `UDWSC_POS_MAX - pos_next; // R8
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			pos_reg <= `UDWSC_POS_MID; // R2 R13
			high_reg <= `UDWSC_POS_MAX - `UDWSC_POS_MID; // R8 R13
			step_reg <= 1'b0;
		end
		else
		begin
			pos_reg <= pos_next; // R1
			high_reg <= high_next; // R8
			step_reg <= step_next;
		end
	end

	assign wiper.wiper_to_low_end_resistance = pos_reg;
	assign wiper.wiper_to_high_end_resistance = high_reg; // R8
	assign step_pulse = step_reg;

	////////////////////////////////////////////////////////////////////////
	// Cycles since the last step pulse, saturating; only the checks read it.
	// The pin filter needs two agreeing samples per level, so steps can never
	// come closer than four cycles apart.
	logic [`UDWSC_GAP_W-1:0] gap_reg, gap_next;

	always_comb
	begin
		gap_next = gap_reg;
		if (step_reg)
		begin
			gap_next = `UDWSC_GAP_ZERO;
		end
		else if (gap_reg != `UDWSC_GAP_MAX)
		begin
			gap_next = gap_reg + `UDWSC_GAP_ONE;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			gap_reg <= `UDWSC_GAP_MAX;
		end
		else
		begin
			gap_reg <= gap_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	AST_MID_AFTER_RESET: assert property ($rose(reset_n) |-> pos_reg == `UDWSC_POS_MID) // R2
		else $error("position not midscale after reset");
	AST_NO_CHANGE_UNSELECTED: assert property (sel_level_reg |=> $stable(pos_reg)) // R12
		else $error("position moved while unselected");
	AST_ONLY_ON_FALL: assert property (!fall |=> $stable(pos_reg)) // R3
		else $error("position moved without a falling edge");
	AST_STEP_UP: assert property (fall && !sel_level_reg && dir_level_reg && pos_reg != `UDWSC_POS_MAX
		|=> pos_reg == $past(pos_reg) + `UDWSC_POS_ONE) // R5
		else $error("up step wrong");
	AST_STEP_DOWN: assert property (fall && !sel_level_reg && !dir_level_reg && pos_reg != `UDWSC_POS_MIN
		|=> pos_reg == $past(pos_reg) - `UDWSC_POS_ONE) // R4
		else $error("down step wrong");
	AST_SAT_TOP: assert property (pos_reg == `UDWSC_POS_MAX && dir_level_reg |=> pos_reg == `UDWSC_POS_MAX) // R6
		else $error("wrapped past top");
	AST_SAT_BOTTOM: assert property (pos_reg == `UDWSC_POS_MIN && !dir_level_reg |=> pos_reg == `UDWSC_POS_MIN) // R6
		else $error("wrapped past bottom");
	AST_COMPLEMENT: assert property (wiper.wiper_to_high_end_resistance + pos_reg == `UDWSC_POS_MAX) // R8
		else $error("portions not complementary");
	AST_PULSE_MARKS_STEP: assert property (step_reg |-> $past(fall) && !$past(sel_level_reg)) // R10
		else $error("step pulse without qualifying edge");

	COV_UP: cover property (step_reg && pos_reg == `UDWSC_POS_MAX);
	COV_DOWN: cover property (step_reg && pos_reg == `UDWSC_POS_MIN);
	AST_HIGH_AFTER_RESET: assert property ($rose(reset_n) |->
		wiper.wiper_to_high_end_resistance == `UDWSC_POS_MAX - `UDWSC_POS_MID) // R13
		else $error("high end not midscale complement after reset");
	AST_HIGH_MIRRORS: assert property (wiper.wiper_to_high_end_resistance ==
		`UDWSC_POS_MAX - wiper.wiper_to_low_end_resistance) // R8
		else $error("high end does not mirror low end");
	AST_MOVE_MARKED: assert property ($changed(pos_reg) |-> step_reg) // R10
		else $error("position moved without a step pulse");
	AST_STEP_SIZE: assert property ($changed(pos_reg) |->
		pos_reg == $past(pos_reg) + `UDWSC_POS_ONE || pos_reg == $past(pos_reg) - `UDWSC_POS_ONE) // R4
		else $error("position moved by more than one step");
	AST_UP_NEEDS_DIR: assert property (pos_reg > $past(pos_reg) |-> $past(dir_level_reg)) // R5
		else $error("position rose while direction was down");
	AST_DOWN_NEEDS_DIR: assert property (pos_reg < $past(pos_reg) |-> !$past(dir_level_reg)) // R5
		else $error("position fell while direction was up");
	AST_NO_WRAP_UP: assert property (pos_reg == `UDWSC_POS_MAX |=> pos_reg != `UDWSC_POS_MIN) // R6
		else $error("position wrapped from top to bottom");
	AST_NO_WRAP_DOWN: assert property (pos_reg == `UDWSC_POS_MIN |=> pos_reg != `UDWSC_POS_MAX) // R6
		else $error("position wrapped from bottom to top");
	AST_PULSE_ONE_CYCLE: assert property (step_reg |=> !step_reg [*3]) // R4
		else $error("step pulse longer than one cycle");
	AST_STEP_SPACING: assert property (step_reg |-> gap_reg >= `UDWSC_GAP_MIN) // R4
		else $error("step pulses closer than the pin filter allows");
	AST_CLK_FILTER: assert property ($changed(clk_level_reg) |->
		$past(clk_sync_reg[1]) == $past(clk_sync_reg[2])) // R3
		else $error("step clock level changed without agreeing samples");
	AST_SEL_FILTER: assert property ($changed(sel_level_reg) |->
		$past(sel_sync_reg[1]) == $past(sel_sync_reg[2])) // R12
		else $error("select level changed without agreeing samples");
	AST_DIR_FILTER: assert property ($changed(dir_level_reg) |->
		$past(dir_sync_reg[1]) == $past(dir_sync_reg[2])) // R5
		else $error("direction level changed without agreeing samples");

	COV_IGNORED: cover property (fall && sel_level_reg);
	COV_RESTORE: cover property ($rose(reset_n) && pos_reg == `UDWSC_POS_MID);
endmodule

// ### design/udwsc_consts.svh
// Notes on behaviour
// R1 - The wiper position counter has 64 positions held in a 6-bit code.
// R2 - At power-on the counter loads midscale without any host action.
// R3 - Position changes only on a falling step clock edge while select is low.
// R4 - Each qualifying pulse moves the position by exactly one step unless it is already at the end in that direction.
// R5 - Direction is sampled at the qualifying edge: high steps up, low steps down.
// R6 - At either end, further steps in that direction leave the position unchanged.
// R7 - A steady direction keeps stepping the same way until the range end.
// R8 - The high-end portion is always 63 minus the low-end position.
// R9 - The host interface is three inputs: step clock, active-low select, direction.
// R10 - With select low, each clock pulse increments or decrements the counter unless it already sits at that end.
// R11 - The host drives direction high for upward steps and low for downward.
// R12 - Select is active low; with select high, clock edges change nothing.
// R13 - Midscale preset is position 32; the position is lost on power removal.
`ifndef UDWSC_CONSTS_SVH
`define UDWSC_CONSTS_SVH
`define UDWSC_POS_W 6
`define UDWSC_POS_MAX 6'h3F
`define UDWSC_POS_MIN 6'h00
`define UDWSC_POS_MID 6'h20
`define UDWSC_POS_ONE 6'h01
`define UDWSC_SYNC_HIGH 3'h7
`define UDWSC_SYNC_LOW 3'h0
`define UDWSC_GAP_W 3
`define UDWSC_GAP_MAX 3'h7
`define UDWSC_GAP_MIN 3'h3
`define UDWSC_GAP_ONE 3'h1
`define UDWSC_GAP_ZERO 3'h0
`endif

// ### design/udwsc_pkg.sv
`include "udwsc_consts.svh"
package udwsc_pkg;
	typedef struct packed
	{
		logic step_clk;
		logic select_n;
		logic dir_up;
	} udwsc_host_t;
	typedef struct packed
	{
		logic [`UDWSC_POS_W-1:0] wiper_to_low_end_resistance;
		logic [`UDWSC_POS_W-1:0] wiper_to_high_end_resistance;
	} udwsc_wiper_t;
endpackage

// ### sim/udwsc_host_model.sv
`timescale 1ns/1ps
module udwsc_host_model
(
	// Clock.
	input wire logic mclk,
	// Host pins.
	output udwsc_pkg::udwsc_host_t host
);
	initial host = '{step_clk: 1'b1, select_n: 1'b1, dir_up: 1'b0};
	// Four cycles a level, two more than the synchronisers need.
	task automatic steps(input logic sel_n, input logic up, input int n);
		@(negedge mclk);
		host.select_n = sel_n;
		host.dir_up = up;
		repeat (4) @(negedge mclk);
		repeat (n)
		begin
			host.step_clk = 1'b0;
			repeat (4) @(negedge mclk);
			host.step_clk = 1'b1;
			repeat (4) @(negedge mclk);
		end
		host.select_n = 1'b1;
		repeat (4) @(negedge mclk);
	endtask
endmodule

// ### sim/tb_updown_wiper_step_counter.sv
`timescale 1ns/1ps
module tb_updown_wiper_step_counter;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	udwsc_pkg::udwsc_host_t host;
	udwsc_pkg::udwsc_wiper_t wiper;
	logic step_pulse;
	int errors = 0;
	int checks_done = 0;
	int pulses = 0;
	always #5 mclk = ~mclk;
	always @(posedge mclk) if (step_pulse === 1'b1) pulses <= pulses + 1;
	udwsc_host_model i_host (.mclk(mclk), .host(host));
	udwsc_counter i_dut (.mclk(mclk), .reset_n(reset_n), .host(host), .wiper(wiper), .step_pulse(step_pulse));
	task automatic check(input string what, input logic [6:0] exp, input logic [6:0] got);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic check_pos(input logic [5:0] exp);
		check("low end", {1'b0, exp}, {1'b0, wiper.wiper_to_low_end_resistance});
		check("high end", {1'b0, 6'h3F - exp}, {1'b0, wiper.wiper_to_high_end_resistance});
	endtask
	// Runs n steps and compares the end position and the pulses seen.
	task automatic run(input logic sel_n, input logic up, input int n, input logic [5:0] pos, input int np);
		int p0;
		p0 = pulses;
		i_host.steps(sel_n, up, n);
		check_pos(pos);
		check("pulses", 7'(np), 7'(pulses - p0));
	endtask
	task automatic single_steps();
		run(1'b0, 1'b1, 1, 6'h21, 1);
		run(1'b0, 1'b0, 1, 6'h20, 1);
	endtask
	task automatic deselected();
		run(1'b1, 1'b1, 3, 6'h20, 0);
	endtask
	task automatic climb_to_top();
		run(1'b0, 1'b1, 33, 6'h3F, 33);
	endtask
	task automatic fall_to_bottom();
		run(1'b0, 1'b0, 70, 6'h00, 70);
	endtask
	// A second reset stands for power removed and restored mid-run.
	task automatic power_cycle();
		@(negedge mclk);
		reset_n = 1'b0;
		repeat (5) @(negedge mclk);
		reset_n = 1'b1;
		repeat (2) @(negedge mclk);
		check_pos(6'h20);
		check("step pulse", 7'h00, {6'h00, step_pulse});
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(negedge mclk);
		reset_n = 1'b1;
		repeat (2) @(negedge mclk);
		check_pos(6'h20);
		single_steps();
		deselected();
		climb_to_top();
		fall_to_bottom();
		power_cycle();
		single_steps();
		conclude();
	end
endmodule
